/* rtl/pwdt_defines.vh */
`ifndef PWDT_DEFINES_VH
`define PWDT_DEFINES_VH

// register byte addresses on the avalon bus
`define PWDT_OFS_DUTY0 8'h00
`define PWDT_OFS_DUTY1 8'h04
`define PWDT_OFS_DUTY2 8'h08
`define PWDT_OFS_DUTY3 8'h0C
`define PWDT_OFS_PERIOD 8'h10
`define PWDT_OFS_DTCTL 8'h14
`define PWDT_OFS_CTL1 8'h18
`define PWDT_OFS_TRIGCMP 8'h1C
`define PWDT_OFS_STATUS 8'h20

// dead time control fields
`define PWDT_DT_PS_HI 7
`define PWDT_DT_PS_LO 6
`define PWDT_DT_CNT_HI 5
`define PWDT_DT_CNT_LO 0
`define PWDT_DTCTL_RST 8'h00

// control one fields
`define PWDT_CTL1_UPDATE_DISABLE 0
`define PWDT_CTL1_TDIR 1
`define PWDT_CTL1_OPS_LO 4
`define PWDT_CTL1_OPS_HI 7
`define PWDT_CTL1_CMPL 8
`define PWDT_CTL1_RST 9'h000

// time base modes
`define PWDT_TB_UPDOWN 2'h2

`endif

/* rtl/pwdt_deadtime.v */
`timescale 1ns/1ps
`include "pwdt_defines.vh"

// one dead-time unit for a complementary output pair
module pwdt_deadtime (
	input wire clk,
	input wire rst_b,
	input wire pwm_in,
	input wire [3:0] q_phase,
	input wire [1:0] match_phase,
	input wire [1:0] tb_prescale,
	input wire [1:0] dt_prescale,
	input wire [5:0] dt_count,
	input wire dt_write,
	input wire complementary,
	output reg out_high,
	output reg out_low
);
	reg pwm_last_q;
	reg [5:0] down_q;
	reg [2:0] pre_q;
	reg [1:0] phase_q;
	reg step_q1;
	reg step_phase;
	reg step;
	wire edge_seen;

	assign edge_seen = pwm_in != pwm_last_q;

	// choose the q clock that advances the counter
	always @* begin
		step_q1 = q_phase[0];
		step_phase = q_phase[phase_q];
		step = 1'b0;
		if (tb_prescale == 2'h0 && dt_prescale == 2'h0)
			// two q clocks per cycle, aligned to the match phase pair
			step = phase_q[0] ? (q_phase[1] | q_phase[3]) : (q_phase[0] | q_phase[2]);
		else if (tb_prescale == 2'h0)
			step = step_phase;
		else
			step = step_q1;
	end

	// prescaler divides the step for /4, /8, /16 settings
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwm_last_q <= 1'b0;
			down_q <= 6'h00;
			pre_q <= 3'h0;
			phase_q <= 2'h0;
			out_high <= 1'b0;
			out_low <= 1'b0;
		end else begin
			pwm_last_q <= pwm_in;
			if (edge_seen) begin
				down_q <= dt_count;
				pre_q <= 3'h0;
				phase_q <= match_phase;
			end else if (dt_write) begin
				pre_q <= 3'h0;
			end else if (step && down_q != 6'h00) begin
				// divisor of 1,2,4,8 steps for /2,/4,/8,/16
				if (pre_q == ((3'h1 << dt_prescale) - 3'h1) || dt_prescale == 2'h0) begin
					pre_q <= 3'h0;
					down_q <= down_q - 6'h01;
				end else begin
					pre_q <= pre_q + 3'h1;
				end
			end
			// in complementary mode outputs stay off while dead time runs; otherwise both follow pwm_in
			if (complementary) begin
				out_high <= pwm_in & ~edge_seen & (down_q == 6'h00);
				out_low <= ~pwm_in & ~edge_seen & (down_q == 6'h00);
			end else begin
				out_high <= pwm_in;
				out_low <= pwm_in;
			end
		end
	end
endmodule

/* rtl/pwdt_trigger.v */
`timescale 1ns/1ps
`include "pwdt_defines.vh"

// special event trigger compare and postscaler
module pwdt_trigger (
	input wire clk,
	input wire rst_b,
	input wire [15:0] time_base,
	input wire tb_tick,
	input wire [1:0] tb_mode,
	input wire tb_down,
	input wire [15:0] compare_value,
	input wire direction_select,
	input wire [3:0] postscale_select,
	input wire compare_write,
	output reg trigger_pulse
);
	reg [3:0] post_q;
	wire dir_ok;
	wire hit;

	// direction only matters in up/down counting
	assign dir_ok = (tb_mode != `PWDT_TB_UPDOWN) || (tb_down == direction_select);
	assign hit = tb_tick && (time_base == compare_value) && dir_ok;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			post_q <= 4'h0;
			trigger_pulse <= 1'b0;
		end else begin
			trigger_pulse <= 1'b0;
			if (compare_write) begin
				post_q <= 4'h0;
			end else if (hit) begin
				if (post_q == postscale_select) begin
					post_q <= 4'h0;
					trigger_pulse <= 1'b1;
				end else begin
					post_q <= post_q + 4'h1;
				end
			end
		end
	end
endmodule

/* rtl/pwdt_core.v */
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "pwdt_defines.vh"

// Notes on behaviour
// - four 14-bit duty values, six high-byte bits plus eight low-byte bits
// - software writes a buffer; compare uses an active copy loaded from it
// - at 1:1, upper 12 bits match time base 11:0, low 2 pick Q phase
// - edge aligned: active from Q1 at period start until the duty match
// - other prescales: match takes effect at Q1 of the matching cycle
// - complementary mode drives pair as complements with dead time between
// - dead-time prescale bits 7-6 pick osc/2, /4, /8 or /16; code runs /4, /8, /16 at osc/8, /16, /32
// - bits 5-0 give dead-time length in prescaled clock periods
// - prescaler cleared on counter load, control write and reset
// - counter steps on Q1 for dt /4-/16 and time base /16-/256
// - both prescales at 00: counter steps on two Q clocks per cycle
// - steps on Q1/Q3 or Q2/Q4 following the phase of the match
// - 1:1 time base with dt /4-/16: steps on the match Q phase
// - while update disable is set no buffer moves to active registers
// - clearing update disable loads all pending buffers together
// - trigger when time base equals the 16-bit compare value
// - direction bit qualifies trigger only in up/down count mode
// - trigger pulses are always produced, no enable bit
// - 4-bit postscaler gives one pulse per 1 to 16 matches
// - postscaler cleared by compare write and by reset
module pwdt_core #(
	parameter CHANNELS = 4
) (
	input wire clk,
	input wire rst_b,
	// avalon-mm slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	// time base from the outside counter
	input wire [15:0] time_base,
	input wire [3:0] q_phase,
	input wire [1:0] tb_prescale,
	input wire [1:0] tb_mode,
	input wire tb_down,
	input wire period_start,
	// outputs
	output wire [15:0] period_active,
	output wire [2*CHANNELS-1:0] pwm_out,
	output wire trigger_pulse
);
	reg [13:0] duty_buf_q [0:CHANNELS-1];
	reg [13:0] duty_act_q [0:CHANNELS-1];
	reg [CHANNELS-1:0] duty_raw_q;
	reg [15:0] period_buf_q;
	reg [15:0] period_act_q;
	reg [7:0] dtctl_q;
	reg [8:0] ctl1_q;
	reg [15:0] trigcmp_q;
	reg dt_write_q;
	reg cmp_write_q;
	reg update_disable_last_q;
	reg rd_pending_q;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg [CHANNELS-1:0] match;
	integer i;
	wire wr_ok;
	wire rd_go;
	wire load_now;
	wire [15:0] duty_merged;

	// merge byte lanes into a stored word
	function [15:0] pwdt_merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [1:0] be;
		begin
			pwdt_merge = {be[1] ? new_val[15:8] : old_val[15:8],
				be[0] ? new_val[7:0] : old_val[7:0]};
		end
	endfunction

	// match for one channel at the current q phase
	function pwdt_duty_hit;
		input [13:0] duty;
		input [15:0] tb;
		input [3:0] q;
		input [1:0] psel;
		begin
			if (psel == 2'h0)
				pwdt_duty_hit = (duty[13:2] == tb[11:0]) && q[duty[1:0]];
			else
				pwdt_duty_hit = (duty[13:2] == tb[11:0]) && q[0];
		end
	endfunction

	// writes land on the cycle of the request; reads take one extra cycle
	assign wr_ok = avs_write;
	assign rd_go = avs_read && !rd_pending_q;
	assign avs_waitrequest = avs_read && !rd_pending_q;
	assign avs_readdata = rdata_q;
	// a load happens on the falling edge of update disable or at each period start while update disable is clear
	assign load_now = (update_disable_last_q && !ctl1_q[`PWDT_CTL1_UPDATE_DISABLE]) ||
		(period_start && !ctl1_q[`PWDT_CTL1_UPDATE_DISABLE]);
	assign period_active = period_act_q;
	// merged duty word is 16 bits wide; only the low 14 are stored
	assign duty_merged = pwdt_merge({2'h0, duty_buf_q[avs_address[3:2]]},
		{2'h0, avs_writedata[13:0]}, avs_byteenable[1:0]);

	// register writes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < CHANNELS; i = i + 1) begin
				duty_buf_q[i] <= 14'h0000;
				duty_act_q[i] <= 14'h0000;
			end
			period_buf_q <= 16'h0000;
			period_act_q <= 16'h0000;
			dtctl_q <= `PWDT_DTCTL_RST;
			ctl1_q <= `PWDT_CTL1_RST;
			trigcmp_q <= 16'h0000;
			dt_write_q <= 1'b0;
			cmp_write_q <= 1'b0;
			update_disable_last_q <= 1'b0;
		end else begin
			dt_write_q <= 1'b0;
			cmp_write_q <= 1'b0;
			update_disable_last_q <= ctl1_q[`PWDT_CTL1_UPDATE_DISABLE];
			if (wr_ok) begin
				case (avs_address)
				`PWDT_OFS_DUTY0, `PWDT_OFS_DUTY1, `PWDT_OFS_DUTY2, `PWDT_OFS_DUTY3: begin
					// high byte keeps its six low bits only
					duty_buf_q[avs_address[3:2]] <= duty_merged[13:0];
				end
				`PWDT_OFS_PERIOD: period_buf_q <= pwdt_merge(period_buf_q, avs_writedata[15:0],
					avs_byteenable[1:0]);
				`PWDT_OFS_DTCTL: begin
					if (avs_byteenable[0]) begin
						dtctl_q <= avs_writedata[7:0];
						dt_write_q <= 1'b1;
					end
				end
				`PWDT_OFS_CTL1: begin
					if (avs_byteenable[0])
						ctl1_q[7:0] <= avs_writedata[7:0];
					if (avs_byteenable[1])
						ctl1_q[8] <= avs_writedata[8];
				end
				`PWDT_OFS_TRIGCMP: begin
					trigcmp_q <= pwdt_merge(trigcmp_q, avs_writedata[15:0], avs_byteenable[1:0]);
					cmp_write_q <= |avs_byteenable[1:0];
				end
				default: begin
				end
				endcase
			end
			// buffers move together, never while locked
			if (load_now) begin
				for (i = 0; i < CHANNELS; i = i + 1)
					duty_act_q[i] <= duty_buf_q[i];
				period_act_q <= period_buf_q;
			end
		end
	end

	// read mux, unmapped reads return zero
	always @* begin
		rdata_d = 32'h00000000;
		case (avs_address)
		`PWDT_OFS_DUTY0, `PWDT_OFS_DUTY1, `PWDT_OFS_DUTY2, `PWDT_OFS_DUTY3:
			rdata_d = {18'h00000, duty_buf_q[avs_address[3:2]]};
		`PWDT_OFS_PERIOD: rdata_d = {16'h0000, period_buf_q};
		`PWDT_OFS_DTCTL: rdata_d = {24'h000000, dtctl_q};
		`PWDT_OFS_CTL1: rdata_d = {23'h000000, ctl1_q};
		`PWDT_OFS_TRIGCMP: rdata_d = {16'h0000, trigcmp_q};
		`PWDT_OFS_STATUS: rdata_d = {{(32-CHANNELS){1'b0}}, duty_raw_q};
		default: rdata_d = 32'h00000000;
		endcase
	end

	// read handshake register
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_pending_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			rd_pending_q <= rd_go;
			if (rd_go)
				rdata_q <= rdata_d;
		end
	end

	// edge-aligned raw pwm per channel
	always @* begin
		for (i = 0; i < CHANNELS; i = i + 1)
			match[i] = pwdt_duty_hit(duty_act_q[i], time_base, q_phase, tb_prescale);
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			duty_raw_q <= {CHANNELS{1'b0}};
		end else begin
			for (i = 0; i < CHANNELS; i = i + 1) begin
				if (match[i])
					duty_raw_q[i] <= 1'b0;
				else if (period_start && q_phase[0] && duty_act_q[i] != 14'h0000)
					duty_raw_q[i] <= 1'b1;
			end
		end
	end

	// one dead-time unit per output pair
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : gen_pair
			pwdt_deadtime u_dt (
				.clk(clk),
				.rst_b(rst_b),
				.pwm_in(duty_raw_q[g]),
				.q_phase(q_phase),
				.match_phase(duty_act_q[g][1:0]),
				.tb_prescale(tb_prescale),
				.dt_prescale(dtctl_q[`PWDT_DT_PS_HI:`PWDT_DT_PS_LO]),
				.dt_count(dtctl_q[`PWDT_DT_CNT_HI:`PWDT_DT_CNT_LO]),
				.dt_write(dt_write_q),
				.complementary(ctl1_q[`PWDT_CTL1_CMPL]),
				.out_high(pwm_out[2*g]),
				.out_low(pwm_out[2*g+1])
			);
		end
	endgenerate

	pwdt_trigger u_trig (
		.clk(clk),
		.rst_b(rst_b),
		.time_base(time_base),
		.tb_tick(q_phase[0]),
		.tb_mode(tb_mode),
		.tb_down(tb_down),
		.compare_value(trigcmp_q),
		.direction_select(ctl1_q[`PWDT_CTL1_TDIR]),
		.postscale_select(ctl1_q[`PWDT_CTL1_OPS_HI:`PWDT_CTL1_OPS_LO]),
		.compare_write(cmp_write_q),
		.trigger_pulse(trigger_pulse)
	);
endmodule

/* tb/pwdt_core_properties.sv */
`timescale 1ns/1ps
`include "pwdt_defines.vh"
// protocol and output checks seen from the core pins
module pwdt_core_properties #(
	parameter CHANNELS = 4
) (
	input wire clk,
	input wire rst_b,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [3:0] q_phase,
	input wire [15:0] period_active,
	input wire [2*CHANNELS-1:0] pwm_out,
	input wire trigger_pulse
);
	reg update_disable_q;
	reg cmpl_q;
	reg [15:0] per_q;
	// shadow of lockout, mode and period buffer from bus writes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			update_disable_q <= 1'b0;
			cmpl_q <= 1'b0;
			per_q <= 16'h0000;
		end else if (avs_write && avs_address == `PWDT_OFS_CTL1) begin
			update_disable_q <= avs_writedata[`PWDT_CTL1_UPDATE_DISABLE];
			cmpl_q <= avs_writedata[`PWDT_CTL1_CMPL];
		end else if (avs_write && avs_address == `PWDT_OFS_PERIOD) begin
			per_q <= avs_writedata[15:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_stall; avs_waitrequest; endsequence
	sequence s_grant; !avs_waitrequest; endsequence
	property p_read_wait; $rose(avs_read) |-> s_stall ##1 s_grant; endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer late");
	property p_write_wait; avs_write |-> s_grant; endproperty
	a_write_wait: assert property (p_write_wait) else $error("write stalled");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address > `PWDT_OFS_STATUS |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_trig_one; trigger_pulse |=> !trigger_pulse; endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger longer than one cycle");
	property p_trig_q1; trigger_pulse |-> $past(q_phase[0]); endproperty
	a_trig_q1: assert property (p_trig_q1) else $error("trigger not from a q1 match");
	property p_overlap;
		cmpl_q && $past(cmpl_q, 2) |-> (pwm_out & (pwm_out >> 1) & {CHANNELS{2'b01}}) == 0;
	endproperty
	a_overlap: assert property (p_overlap) else $error("pair outputs overlap");
	property p_lockout; $past(update_disable_q) |-> $stable(period_active); endproperty
	a_lockout: assert property (p_lockout) else $error("period moved while locked");
	property p_load; $fell(update_disable_q) |-> ##[1:2] period_active == per_q; endproperty
	a_load: assert property (p_load) else $error("period not loaded on unlock");
	property p_reset_zero; $rose(rst_b) |-> pwm_out == 0 && !trigger_pulse; endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear after reset");
endmodule
bind pwdt_core pwdt_core_properties #(.CHANNELS(CHANNELS)) u_props (.clk(clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .q_phase(q_phase), .period_active(period_active),
	.pwm_out(pwm_out), .trigger_pulse(trigger_pulse));

/* tb/pwdt_power_stage.sv */
`timescale 1ns/1ps
// switching stage: counts cross-conduction on any leg and low-to-high gap of leg 0
module pwdt_power_stage (
	input wire clk,
	input wire [7:0] gate,
	output reg [15:0] overlap,
	output reg [7:0] gap
);
	reg [7:0] idle_q;
	initial begin
		overlap = 16'h0000;
		gap = 8'h00;
		idle_q = 8'h00;
	end
	// both switches of a leg on at once would short the rail
	always @(posedge clk) begin
		if ((gate & (gate >> 1) & 8'h55) != 8'h00)
			overlap <= overlap + 16'h0001;
		idle_q <= (gate[1:0] == 2'b00) ? idle_q + 8'h01 : 8'h00;
		if (gate[0] && idle_q != 8'h00)
			gap <= idle_q;
	end
endmodule

/* tb/pwdt_core_test.sv */
`timescale 1ns/1ps
`include "pwdt_defines.vh"
module pwdt_core_test;
	reg clk, rst_b, avs_read, avs_write, tb_down;
	reg [7:0] avs_address;
	reg [31:0] avs_writedata, r;
	reg [3:0] avs_byteenable, q_phase;
	reg [15:0] time_base;
	reg [1:0] tb_prescale, tb_mode;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, trigger_pulse;
	wire [15:0] period_active, overlap;
	wire [7:0] pwm_out, gap;
	wire period_start = (time_base == 16'h0000);
	integer errors, tests_run, seed, cyc, trig_cnt, i, k;
	reg [31:0] exp_q[$];
	pwdt_core u_pwdt_core (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .time_base(time_base), .q_phase(q_phase),
		.tb_prescale(tb_prescale), .tb_mode(tb_mode), .tb_down(tb_down),
		.period_start(period_start), .period_active(period_active), .pwm_out(pwm_out),
		.trigger_pulse(trigger_pulse));
	pwdt_power_stage u_pwdt_power_stage (.clk(clk), .gate(pwm_out), .overlap(overlap), .gap(gap));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// q phases rotate each clock; time base steps every 4 clocks and wraps after 64 clocks
	always @(posedge clk) begin
		q_phase <= {q_phase[2:0], q_phase[3]};
		if (q_phase[3])
			time_base <= (time_base == 16'h000F) ? 16'h0000 : time_base + 16'h0001;
		if (trigger_pulse === 1'b1)
			trig_cnt <= trig_cnt + 1;
		cyc <= cyc + 1;
	end
	// hang guard, well above the expected run length
	always @(posedge clk) begin
		if (cyc == 20000) begin
			errors = errors + 1;
			complete_run;
		end
	end
	// read data stands at the edge where waitrequest is sampled low
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk(avs_readdata, exp_q.pop_front());
	end
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// one bus cycle; for reads d is the expected data
	task xfer(input w, input [7:0] a, input [31:0] d);
		begin
			if (!w)
				exp_q.push_back(d);
			@(posedge clk);
			avs_address <= a;
			avs_writedata <= w ? d : 32'h0;
			avs_write <= w;
			avs_read <= !w;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0)
				@(posedge clk);
			avs_write <= 1'b0;
			avs_read <= 1'b0;
		end
	endtask
	// write control first, then the compare near period start so every window holds whole matches
	task trig_run(input [31:0] ctl, input integer len, input integer exp);
		begin
			xfer(1, `PWDT_OFS_CTL1, ctl);
			while (time_base !== 16'h0000)
				@(posedge clk);
			xfer(1, `PWDT_OFS_TRIGCMP, 32'h5);
			k = trig_cnt;
			repeat (len) @(posedge clk);
			chk(trig_cnt - k, exp);
		end
	endtask
	task complete_run;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		seed = 32'hf998;
		{errors, tests_run, cyc, trig_cnt} = 0;
		{rst_b, avs_read, avs_write, tb_down, avs_address, avs_writedata} = 0;
		{tb_prescale, tb_mode, time_base} = 0;
		avs_byteenable = 4'h3;
		q_phase = 4'h1;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		xfer(0, `PWDT_OFS_DTCTL, 32'h0);
		xfer(0, 8'h24, 32'h0);
		$display("reset test done");
		for (i = 0; i < 4; i = i + 1) begin
			r = $random(seed);
			xfer(1, {i[5:0], 2'b00}, r & 32'hFFFF);
			xfer(0, {i[5:0], 2'b00}, r & 32'h3FFF);
		end
		r = $random(seed) & 32'hFF;
		xfer(1, `PWDT_OFS_DTCTL, r);
		xfer(0, `PWDT_OFS_DTCTL, r);
		$display("buffer test done");
		xfer(1, `PWDT_OFS_CTL1, 32'h1);
		xfer(1, `PWDT_OFS_PERIOD, 32'h40);
		repeat (130) @(posedge clk);
		chk({16'h0, period_active}, 32'h0);
		xfer(1, `PWDT_OFS_CTL1, 32'h0);
		repeat (3) @(posedge clk);
		chk({16'h0, period_active}, 32'h40);
		$display("lockout test done");
		for (i = 0; i < 4; i = i + 1)
			trig_run(((1 << i) - 1) << 4, 512, 8 >> i);
		tb_mode <= `PWDT_TB_UPDOWN;
		tb_down <= 1'b1;
		trig_run(32'h0, 256, 0);
		trig_run(32'h2, 256, 4);
		tb_mode <= 2'h0;
		tb_down <= 1'b0;
		$display("trigger test done");
		xfer(1, `PWDT_OFS_CTL1, 32'h100);
		xfer(1, `PWDT_OFS_DUTY0, 32'h22);
		xfer(1, `PWDT_OFS_DTCTL, 32'h4);
		repeat (128) @(posedge clk);
		k = overlap;
		repeat (256) @(posedge clk);
		chk(overlap - k, 32'h0);
		chk(gap >= 8'h08 && gap <= 8'h0A, 32'h1);
		$display("dead time test done");
		complete_run;
	end
endmodule
